// ===== verilog/ssc_serial_tx.v
// ssc_serial_tx: synchronous serial port, transmit side, with its
// registers, clock selection and shift engine.
// assumes a register master that keeps strobes one cycle long and never
// asks for a read and a write at once; pins are synchronous to the core.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "ssc_consts.vh"

// What this block does
// - internal clock driven on pin, high when idle
// - clock codes select high or low clock divisions
// - missing data halts clock, resumes within period
// - code 111 takes clock from pin
// - shift out on falling, sample on rising
// - one bit order for both directions
// - mode 00 selects transmit only
// - progress flag rises at first falling edge
// - bits leave on falling edges in order
// - shift-count flag high from edge one to eight
// - buffer write clears empty, refill sets, request
// - internal clock waits for written data
// - internal clock loads shifter at first falling edge
// - external first falling edge loads shifter
// - byte written in time follows without gap
// - external underrun sets error, then request
// - cleared start finishes byte, then idles high
// - force stop resets start, status, buffers
// - force stop bit clears itself
// - write to full buffer is discarded
// - output held high while error set
module ssc_serial_tx
(
	input  wire        core_clk_in,
	input  wire        rstn_in,
	input  wire [7:0]  bus_addr_in,
	input  wire [7:0]  bus_wdata_in,
	input  wire        bus_wr_in,
	input  wire        bus_rd_in,
	output wire [7:0]  bus_rdata_out,
	input  wire        time_base_select_in,
	input  wire        slow_mode_in,
	input  wire        low_clock_tick_in,
	input  wire        clock_pin_in,
	output wire        clock_pin_out,
	output wire        clock_pin_oe_out,
	output wire        serial_output_pin_out,
	output wire        serial_interrupt_request_out
);

	// serial_control_reg
	reg        start_q;
	reg        force_q;
	reg  [1:0] mode_q;
	reg        dir_q;
	reg  [2:0] sel_q;

	// serial_status_reg
	reg        tip_q;
	reg        sef_q;
	reg        txf_q;
	reg        transmit_error_flag_q;

	// transmit path
	reg  [7:0] tdb_q;
	reg  [7:0] shreg_q;
	reg  [3:0] bitcnt_q;
	reg        so_q;
	reg        txf_pend_q;
	reg        irq_arm_q;
	reg        irq_q;
	reg  [7:0] rdata_q;

	wire       ext_clk;
	wire       tx_mode;
	wire       mid_byte;
	wire       need_load;
	wire       have_data;
	wire       run;
	wire       tick;
	wire       fall_raw;
	wire       rise_raw;
	wire       sck_level;
	wire       fall_ev;
	wire       rise_ev;
	wire       wr_ctrl;
	wire       wr_stat;
	wire       wr_buf;
	wire [7:0] ctrl_val;
	wire [7:0] stat_val;

	// bit that leaves the shifter first for the chosen order
	function first_bit;
		input [7:0] data;
		input       lsb_first;
		begin
			first_bit = lsb_first ? data[0] : data[7];
		end
	endfunction

	// shifter contents after one bit has left
	function [7:0] shifted;
		input [7:0] data;
		input       lsb_first;
		begin
			shifted = lsb_first ? {1'b0, data[7:1]} : {data[6:0], 1'b0};
		end
	endfunction

	// register port decode
	assign wr_ctrl = bus_wr_in & (bus_addr_in == `SSC_OFS_CTRL);
	assign wr_stat = bus_wr_in & (bus_addr_in == `SSC_OFS_STAT);
	assign wr_buf  = bus_wr_in & (bus_addr_in == `SSC_OFS_BUF);

	// mode decode and engine conditions
	// a byte boundary is either the idle count 0 or the finished count 8;
	// both ask for a fresh load at the next falling edge, which lets a
	// byte that was written in time follow the previous one with no gap.
	// bit counting goes on through an underrun, so the end of a bad byte
	// still lands on the same edge as a good one would.
	assign ext_clk   = (sel_q == `SSC_SEL_EXT);
	assign tx_mode   = (mode_q == `SSC_MODE_TX);
	assign mid_byte  = (bitcnt_q != 4'h0) & (bitcnt_q != `SSC_BITS);
	assign need_load = ~mid_byte;
	assign have_data = ~txf_q;

	// the divider runs only while a byte is in flight, the pin is low, or
	// a started transfer has data; otherwise the clock waits high
	// keeping the low level in the run term lets a low phase always finish,
	// so the pin never parks low when software is slow to refill.
	// the divider restarts from zero on each wait, which bounds the resume
	// delay to one half period plus the register stage of the tick.
	assign run = ~ext_clk & tx_mode & ~force_q
		& (~sck_level | mid_byte | (start_q & have_data));

	// serial edges reach the engine only in transmit mode
	assign fall_ev = fall_raw & tx_mode & ~force_q;
	assign rise_ev = rise_raw & tx_mode & ~force_q;

	ssc_clkdiv u_div
	(
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.run_in      (run),
		.sel_in      (sel_q),
		.tb_sel_in   (time_base_select_in),
		.slow_in     (slow_mode_in),
		.low_tick_in (low_clock_tick_in),
		.tick_out    (tick)
	);

	ssc_sckpin u_pin
	(
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.ext_in      (ext_clk),
		.tick_in     (tick),
		.park_in     (force_q),
		.pin_in      (clock_pin_in),
		.fall_out    (fall_raw),
		.rise_out    (rise_raw),
		.level_out   (sck_level),
		.pin_out     (clock_pin_out),
		.pin_oe_out  (clock_pin_oe_out)
	);

	// serial_control_reg; the force-stop bit lives for one cycle
	// the stop bit is seen by the engine one edge after the write and is
	// gone again one edge later, so software reading back control right
	// after a stop sees it already cleared.
	// mode, order and clock code are taken on every write; changing them
	// mid-transfer is the user's hazard and is not guarded here.
	always @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			start_q <= 1'b0;
			force_q <= 1'b0;
			mode_q  <= 2'h0;
			dir_q   <= 1'b0;
			sel_q   <= 3'h0;
		end
		else if (wr_ctrl)
		begin
			// a force stop also drops the start bit at once
			start_q <= bus_wdata_in[`SSC_CTRL_START] & ~bus_wdata_in[`SSC_CTRL_STOP];
			force_q <= bus_wdata_in[`SSC_CTRL_STOP];
			mode_q  <= bus_wdata_in[`SSC_CTRL_MODE_HI:`SSC_CTRL_MODE_LO];
			dir_q   <= bus_wdata_in[`SSC_CTRL_DIR];
			sel_q   <= bus_wdata_in[`SSC_CTRL_SEL_HI:`SSC_CTRL_SEL_LO];
		end
		else if (force_q)
		begin
			force_q <= 1'b0;
			start_q <= 1'b0;
		end
	end

	// status flags, transmit buffer and shift engine
	// a force stop outranks every other event in the same cycle, so a
	// falling edge that coincides with the stop shifts nothing.
	// the buffer write and the error clear come first in the body and the
	// hardware sets after them, so a set in the same cycle wins.
	// the request is armed on one serial edge and leaves on a later one,
	// which keeps it one core clock wide whatever the serial rate.
	always @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tip_q      <= 1'b0;
			sef_q      <= 1'b0;
			txf_q      <= 1'b1;
			transmit_error_flag_q    <= 1'b0;
			tdb_q      <= `SSC_BUF_RST;
			shreg_q    <= `SSC_BUF_RST;
			bitcnt_q   <= 4'h0;
			so_q       <= 1'b1;
			txf_pend_q <= 1'b0;
			irq_arm_q  <= 1'b0;
			irq_q      <= 1'b0;
		end
		else if (force_q)
		begin
			// force stop: everything back to its reset value
			tip_q      <= 1'b0;
			sef_q      <= 1'b0;
			txf_q      <= 1'b1;
			transmit_error_flag_q    <= 1'b0;
			tdb_q      <= `SSC_BUF_RST;
			shreg_q    <= `SSC_BUF_RST;
			bitcnt_q   <= 4'h0;
			so_q       <= 1'b1;
			txf_pend_q <= 1'b0;
			irq_arm_q  <= 1'b0;
			irq_q      <= 1'b0;
		end
		else
		begin
			irq_q <= 1'b0;

			// software side first, so that hardware sets below win
			if (wr_buf && txf_q)
			begin
				tdb_q <= bus_wdata_in;
				txf_q <= 1'b0;
			end
			if (wr_stat && !bus_wdata_in[`SSC_STAT_TRANSMIT_ERROR_FLAG])
				transmit_error_flag_q <= 1'b0;

			if (fall_ev)
			begin
				// a request armed earlier leaves at this falling edge
				if (irq_arm_q)
				begin
					irq_q     <= 1'b1;
					irq_arm_q <= 1'b0;
				end
				if (need_load)
				begin
					if (start_q)
					begin
						// first edge of a byte: flags rise together
						tip_q    <= 1'b1;
						sef_q    <= 1'b1;
						bitcnt_q <= 4'h1;
						if (have_data)
						begin
							// buffer moves to the shifter; back to back
							// when the byte was already waiting
							shreg_q    <= shifted(tdb_q, dir_q);
							so_q       <= transmit_error_flag_q | first_bit(tdb_q, dir_q);
							txf_pend_q <= 1'b1;
						end
						else
						begin
							// shifting began with no new byte: underrun
							transmit_error_flag_q   <= 1'b1;
							irq_arm_q <= 1'b1;
							so_q      <= 1'b1;
						end
					end
				end
				else
				begin
					// next bit on each falling edge
					bitcnt_q <= bitcnt_q + 4'h1;
					if (bitcnt_q == `SSC_BITS - 4'h1)
						sef_q <= 1'b0;
					shreg_q <= shifted(shreg_q, dir_q);
					so_q    <= transmit_error_flag_q | first_bit(shreg_q, dir_q);
				end
			end

			// buffer becomes free at the rising edge after its load
			if (rise_ev && txf_pend_q)
			begin
				txf_q      <= 1'b1;
				txf_pend_q <= 1'b0;
				irq_arm_q  <= 1'b1;
			end

			// with start cleared, a finished byte ends the transfer
			if (bitcnt_q == `SSC_BITS && !start_q && sck_level && !fall_ev)
			begin
				tip_q    <= 1'b0;
				bitcnt_q <= 4'h0;
				so_q     <= 1'b1;
			end
		end
	end

	// register values as software sees them
	// receive flags and the unused low status bits read as zero, since
	// this block carries only the transmit side of the port.
	assign ctrl_val = {start_q, force_q, mode_q, dir_q, sel_q};
	assign stat_val = {tip_q, sef_q, txf_q, 1'b0, transmit_error_flag_q, 1'b0, 2'h0};

	// read data stand one cycle after the read strobe; the receive buffer
	// belongs to the receive side and reads as its reset value here
	always @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rdata_q <= 8'h00;
		else if (bus_rd_in)
		begin
			case (bus_addr_in)
				`SSC_OFS_CTRL: rdata_q <= ctrl_val;
				`SSC_OFS_STAT: rdata_q <= stat_val;
				`SSC_OFS_BUF:  rdata_q <= `SSC_BUF_RST;
				default:       rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end

	assign bus_rdata_out                = rdata_q;
	assign serial_output_pin_out        = so_q;
	assign serial_interrupt_request_out = irq_q;

endmodule

// ===== verilog/ssc_consts.vh
// ssc_consts.vh: offsets, field positions, reset values and clock counts
// of the synchronous serial transmit block; included by every ssc_ design module.
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// register offsets on the plain register port
`define SSC_OFS_CTRL      8'h20
`define SSC_OFS_STAT      8'h21
`define SSC_OFS_BUF       8'h22

// serial_control_reg fields
`define SSC_CTRL_START    7
`define SSC_CTRL_STOP     6
`define SSC_CTRL_MODE_HI  5
`define SSC_CTRL_MODE_LO  4
`define SSC_CTRL_DIR      3
`define SSC_CTRL_SEL_HI   2
`define SSC_CTRL_SEL_LO   0
`define SSC_CTRL_RST      8'h00

// serial_status_reg fields
`define SSC_STAT_TIP      7
`define SSC_STAT_SEF      6
`define SSC_STAT_TXF      5
`define SSC_STAT_RXF      4
`define SSC_STAT_TRANSMIT_ERROR_FLAG    3
`define SSC_STAT_RXERR    2
`define SSC_STAT_RST      8'h20

// receive and transmit buffer reset values
`define SSC_BUF_RST       8'h00

// transfer modes and clock-select codes
`define SSC_MODE_TX       2'h0
`define SSC_SEL_EXT       3'h7
`define SSC_SEL_SLOWEST   3'h0

// half serial periods in core clocks (high clock) or in low-clock ticks
`define SSC_HALF_SEL0     12'h800
`define SSC_HALF_SEL1     12'h080
`define SSC_HALF_SEL2     12'h040
`define SSC_HALF_SEL3     12'h020
`define SSC_HALF_SEL4     12'h010
`define SSC_HALF_SEL5     12'h008
`define SSC_HALF_SEL6     12'h004
`define SSC_HALF_LOW      12'h008

// bits per byte
`define SSC_BITS          4'h8

`endif

// ===== verilog/ssc_clkdiv.v
// ssc_clkdiv: serial clock divider, one tick per half serial period.
// assumes the core clock is the high clock and low_tick_in is a one-cycle
// pulse per low-clock period, synchronous to the core clock.
`timescale 1ns/10ps
`include "ssc_consts.vh"

module ssc_clkdiv
(
	input  wire        core_clk_in,
	input  wire        rstn_in,
	input  wire        run_in,
	input  wire [2:0]  sel_in,
	input  wire        tb_sel_in,
	input  wire        slow_in,
	input  wire        low_tick_in,
	output reg         tick_out
);

	reg  [11:0] cnt_q;
	wire        low_src;
	wire [11:0] half;
	wire        step;

	// half period per select code; zero marks a reserved code (no clock)
	function [11:0] half_len;
		input [2:0] sel;
		input       low;
		input       slow;
		begin
			case (sel)
				3'h0:    half_len = low ? `SSC_HALF_LOW : `SSC_HALF_SEL0;
				3'h1:    half_len = slow ? 12'h000 : `SSC_HALF_SEL1;
				3'h2:    half_len = slow ? 12'h000 : `SSC_HALF_SEL2;
				3'h3:    half_len = slow ? 12'h000 : `SSC_HALF_SEL3;
				3'h4:    half_len = slow ? 12'h000 : `SSC_HALF_SEL4;
				3'h5:    half_len = slow ? 12'h000 : `SSC_HALF_SEL5;
				3'h6:    half_len = slow ? 12'h000 : `SSC_HALF_SEL6;
				default: half_len = 12'h000;
			endcase
		end
	endfunction

	assign low_src = (sel_in == `SSC_SEL_SLOWEST) & (tb_sel_in | slow_in);
	assign half    = half_len(sel_in, low_src, slow_in);
	assign step    = low_src ? low_tick_in : 1'b1;

	// count restarts whenever the clock is held, so a restart costs at most
	// one half period
	always @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt_q    <= 12'h000;
			tick_out <= 1'b0;
		end
		else if (!run_in || half == 12'h000)
		begin
			cnt_q    <= 12'h000;
			tick_out <= 1'b0;
		end
		else if (step)
		begin
			if (cnt_q == half - 12'h001)
			begin
				cnt_q    <= 12'h000;
				tick_out <= 1'b1;
			end
			else
			begin
				cnt_q    <= cnt_q + 12'h001;
				tick_out <= 1'b0;
			end
		end
		else
			tick_out <= 1'b0;
	end

endmodule

// ===== verilog/ssc_sckpin.v
// ssc_sckpin: clock pin driver and serial edge detector.
// assumes the pin input is synchronous to the core clock.
`timescale 1ns/10ps
`include "ssc_consts.vh"

module ssc_sckpin
(
	input  wire        core_clk_in,
	input  wire        rstn_in,
	input  wire        ext_in,
	input  wire        tick_in,
	input  wire        park_in,
	input  wire        pin_in,
	output wire        fall_out,
	output wire        rise_out,
	output wire        level_out,
	output wire        pin_out,
	output wire        pin_oe_out
);

	reg lvl_q;
	reg pin_q;

	// internal level toggles per tick and parks high outside transfers
	always @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			lvl_q <= 1'b1;
			pin_q <= 1'b1;
		end
		else
		begin
			pin_q <= pin_in;
			if (park_in || ext_in)
				lvl_q <= 1'b1;
			else if (tick_in)
				lvl_q <= ~lvl_q;
		end
	end

	// edges come from the divider or from the pin
	assign fall_out   = ext_in ? (pin_q & ~pin_in) : (tick_in & lvl_q);
	assign rise_out   = ext_in ? (~pin_q & pin_in) : (tick_in & ~lvl_q);
	assign level_out  = ext_in ? pin_q : lvl_q;
	assign pin_out    = lvl_q;
	assign pin_oe_out = ~ext_in;

endmodule

// ===== test/ssc_serial_tx_properties.sv
// ssc_serial_tx_properties: port checks of the serial transmit block.
// assumes it is bound into ssc_serial_tx and sees only its ports.
`timescale 1ns/10ps

module ssc_serial_tx_properties
(
	input wire       core_clk_in,
	input wire       rstn_in,
	input wire [7:0] bus_addr_in,
	input wire [7:0] bus_wdata_in,
	input wire       bus_wr_in,
	input wire       bus_rd_in,
	input wire [7:0] bus_rdata_out,
	input wire       clock_pin_out,
	input wire       clock_pin_oe_out,
	input wire       serial_output_pin_out,
	input wire       serial_interrupt_request_out
);
	reg  [2:0] sel_q;
	wire       ctl_wr = bus_wr_in && bus_addr_in == 8'h20;
	wire       stop_wr = ctl_wr && bus_wdata_in[6];

	// clock code last written, for the rate check
	always @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			sel_q <= 3'h0;
		else if (ctl_wr)
			sel_q <= bus_wdata_in[2:0];
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_oe_external: assert property (ctl_wr && bus_wdata_in[2:0] == 3'h7 |=> !clock_pin_oe_out)
		else $error("clock pin driven on external code");
	chk_idle_reset: assert property ($rose(rstn_in) |-> clock_pin_out && serial_output_pin_out)
		else $error("pins not high after reset");
	chk_irq_single: assert property ($rose(serial_interrupt_request_out) |=> !serial_interrupt_request_out)
		else $error("irq longer than one cycle");
	chk_irq_clock_low: assert property (serial_interrupt_request_out && clock_pin_oe_out |-> !clock_pin_out)
		else $error("irq outside a low clock phase");
	chk_sck_half: assert property ($fell(clock_pin_out) && sel_q == 3'h6 |-> !clock_pin_out[*4] ##1 clock_pin_out)
		else $error("low phase not four cycles");
	chk_data_steady: assert property (clock_pin_oe_out && !clock_pin_out && !$past(clock_pin_out)
		|-> $stable(serial_output_pin_out))
		else $error("data moved while clock low");
	chk_stop_pins: assert property (stop_wr |-> ##2 clock_pin_out && serial_output_pin_out)
		else $error("pins not high after stop");
	chk_stop_status: assert property (stop_wr ##2 (bus_rd_in && bus_addr_in == 8'h21) |=> bus_rdata_out == 8'h20)
		else $error("status not initial after stop");
	chk_stop_clears: assert property (stop_wr ##2 (bus_rd_in && bus_addr_in == 8'h20) |=> bus_rdata_out[7:6] == 2'h0)
		else $error("stop or start bit left set");
endmodule

bind ssc_serial_tx ssc_serial_tx_properties chk
(
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .bus_addr_in(bus_addr_in),
	.bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
	.bus_rdata_out(bus_rdata_out), .clock_pin_out(clock_pin_out),
	.clock_pin_oe_out(clock_pin_oe_out), .serial_output_pin_out(serial_output_pin_out),
	.serial_interrupt_request_out(serial_interrupt_request_out)
);

// ===== test/ssc_peer.sv
// ssc_peer: far-side serial peer; captures data on rising clock edges
// and drives eight-pulse clock bursts. assumes pin_in is the pin level.
`timescale 1ns/10ps

module ssc_peer
(
	input  wire        core_clk_in,
	input  wire        go_in,
	input  wire        pin_in,
	input  wire        sdo_in,
	output reg         sck_out,
	output reg  [15:0] rx_out,
	output wire        busy_out
);
	reg [3:0] left_q = 4'h0;
	reg [2:0] ph_q = 3'h0;
	reg       pin_q = 1'b1;

	initial sck_out = 1'b1;
	initial rx_out = 16'h0000;
	assign busy_out = left_q != 4'h0;

	// bursts with five core clocks per phase; clock rests high between
	always @(posedge core_clk_in)
	begin
		ph_q <= (go_in || ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
		if (go_in)
			left_q <= 4'h8;
		else if (busy_out && ph_q == 3'h4)
		begin
			sck_out <= ~sck_out;
			if (!sck_out)
				left_q <= left_q - 4'h1;
		end
	end

	// shift in the data line on each rising pin edge
	always @(posedge core_clk_in)
	begin
		pin_q <= pin_in;
		if (pin_in && !pin_q)
			rx_out <= {rx_out[14:0], sdo_in};
	end
endmodule

// ===== test/tb_sync_serial_clock_and_transmit.sv
// tb_sync_serial_clock_and_transmit: self-checking bench of the block.
// assumes the peer model and the bound checker beside the design.
`timescale 1ns/10ps
`define CHK(n, e, g) \
	begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", n, e, g); end end

module tb_sync_serial_clock_and_transmit;
	reg         core_clk = 1'b0;
	reg         rstn;
	reg  [7:0]  addr;
	reg  [7:0]  wdata;
	reg         wr_s;
	reg         rd_s;
	reg         tbsel;
	reg         slow;
	reg         ltick;
	reg  [1:0]  lt_cnt;
	reg         go;
	reg  [7:0]  v;
	reg  [7:0]  d;
	reg  [31:0] rnd;
	integer     nirq;
	integer     k;
	integer     i;
	integer     num_errors;
	integer     tests_run;
	wire [7:0]  rdata;
	wire        sck_o;
	wire        oe;
	wire        sdo;
	wire        irq;
	wire        psck;
	wire [15:0] rx;
	wire        pbusy;
	wire        pin = oe ? sck_o : psck;

	ssc_serial_tx DUT
	(
		.core_clk_in(core_clk), .rstn_in(rstn), .bus_addr_in(addr), .bus_wdata_in(wdata),
		.bus_wr_in(wr_s), .bus_rd_in(rd_s), .bus_rdata_out(rdata),
		.time_base_select_in(tbsel), .slow_mode_in(slow), .low_clock_tick_in(ltick),
		.clock_pin_in(pin), .clock_pin_out(sck_o), .clock_pin_oe_out(oe),
		.serial_output_pin_out(sdo), .serial_interrupt_request_out(irq)
	);

	ssc_peer peer
	(
		.core_clk_in(core_clk), .go_in(go), .pin_in(pin), .sdo_in(sdo),
		.sck_out(psck), .rx_out(rx), .busy_out(pbusy)
	);

	always #25 core_clk = ~core_clk;

	// count interrupt pulses and make a low-clock tick every four cycles
	always @(posedge core_clk)
	begin
		if (irq === 1'b1)
			nirq <= nirq + 1;
		lt_cnt <= lt_cnt + 2'h1;
		ltick <= lt_cnt == 2'h3;
	end

	// expected order of bits on the line
	function [7:0] ord(input [7:0] x, input dir);
		integer j;
	begin
		for (j = 0; j < 8; j++)
			ord[j] = dir ? x[7 - j] : x[j];
	end
	endfunction

	task summarize;
	begin
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	// register bus cycles, each followed by one idle cycle
	task wr(input [7:0] a, input [7:0] x);
	begin
		addr <= a;
		wdata <= x;
		wr_s <= 1'b1;
		@(posedge core_clk);
		wr_s <= 1'b0;
		@(posedge core_clk);
	end
	endtask

	task rd(input [7:0] a, output [7:0] x);
	begin
		addr <= a;
		rd_s <= 1'b1;
		@(posedge core_clk);
		rd_s <= 1'b0;
		#1 x = rdata;
		@(posedge core_clk);
	end
	endtask

	// bounded waits: status bits, then the end of a peer burst
	task poll(input [7:0] m, input [7:0] x);
		integer n;
	begin
		n = 0;
		rd(8'h21, v);
		while ((v & m) !== x && n < 3000)
		begin
			rd(8'h21, v);
			n = n + 1;
		end
		if (n == 3000)
		begin
			`CHK("status wait", x, v & m)
			summarize;
		end
	end
	endtask

	task burst_end;
		integer n;
	begin
		n = 0;
		while (pbusy !== 1'b0 && n < 300)
		begin
			@(posedge core_clk);
			n = n + 1;
		end
		`CHK("burst end", 1'b1, n < 300)
		if (n == 300)
			summarize;
	end
	endtask

	task kick;
	begin
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
	end
	endtask

	// internal clock transfer: one byte, with a dropped second write when pre is clear, or
	// two bytes back to back; pre starts the port before any data
	task run(input [2:0] code, input dir, input two, input pre);
		reg [7:0]  a;
		reg [7:0]  b;
		reg [7:0]  ctl;
		reg [15:0] e;
		integer    n;
	begin
		rnd = $urandom;
		a = rnd[7:0];
		b = rnd[15:8];
		ctl = {4'h8, dir, code};
		k = nirq;
		if (pre)
		begin
			wr(8'h20, ctl);
			repeat (20) @(posedge core_clk);
			`CHK("clock held", 1'b1, sck_o)
		end
		wr(8'h22, a);
		if (pre)
		begin
			n = 0;
			while (sck_o === 1'b1 && n < 20)
			begin
				@(posedge core_clk);
				n = n + 1;
			end
			`CHK("clock resume", 1'b1, n < 8)
		end
		else
		begin
			rd(8'h21, v);
			`CHK("empty flag", 1'b0, v[5])
			if (!two)
				wr(8'h22, b);
			wr(8'h20, ctl);
		end
		if (two)
		begin
			poll(8'h20, 8'h20);
			wr(8'h22, b);
		end
		poll(8'h20, 8'h20);
		wr(8'h20, ctl & 8'h7F);
		poll(8'h80, 8'h00);
		e = two ? {ord(a, dir), ord(b, dir)} : {8'h00, ord(a, dir)};
		`CHK("line data", e, two ? rx : {8'h00, rx[7:0]})
		`CHK("line idle", 1'b1, sdo)
		`CHK("irq pulses", k + (two ? 2 : 1), nirq)
		$display("test code %0d dir %0d two %0d done", code, dir, two);
	end
	endtask

	initial
	begin
		{rstn, addr, wdata, wr_s, rd_s, tbsel, slow, ltick, go, lt_cnt} = 0;
		{nirq, num_errors, tests_run} = 0;
		rnd = $urandom(32'hD2A797E4);
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rd(8'h21, v);
		`CHK("status reset", 8'h20, v)
		rd(8'h30, v);
		`CHK("unmapped read", 8'h00, v)
		run(3'h6, 1'b0, 1'b0, 1'b1);
		run(3'h5, 1'b1, 1'b1, 1'b0);
		tbsel <= 1'b1;
		for (i = 0; i < 7; i++)
		begin
			rnd = $urandom;
			run(i[2:0], rnd[0], i == 3, 1'b0);
		end
		// external clock: one byte, then an underrun and a forced stop
		rnd = $urandom;
		d = rnd[7:0];
		k = nirq;
		wr(8'h22, d);
		wr(8'h20, 8'h87);
		kick;
		poll(8'h20, 8'h20);
		wr(8'h20, 8'h07);
		burst_end;
		poll(8'h80, 8'h00);
		`CHK("ext data", d, rx[7:0])
		wr(8'h20, 8'h87);
		kick;
		burst_end;
		rd(8'h21, v);
		`CHK("underrun flag", 1'b1, v[3])
		`CHK("held high", 8'hFF, rx[7:0])
		`CHK("irq pulses", k + 2, nirq)
		wr(8'h20, 8'h47);
		rd(8'h21, v);
		`CHK("status stop", 8'h20, v)
		$display("test external done");
		// reserved code in slow mode gives no clock
		slow <= 1'b1;
		wr(8'h22, 8'hA5);
		wr(8'h20, 8'h83);
		repeat (40) @(posedge core_clk);
		`CHK("reserved code", 1'b1, sck_o)
		wr(8'h20, 8'h43);
		rd(8'h20, v);
		`CHK("stop bit clear", 2'h0, v[7:6])
		$display("test slow done");
		summarize;
	end
endmodule
